// ===== cms_pkg.sv
// Constants shared by the control mode pin select logic
package cms_pkg;

	// ************************************************************
	// Register map (byte addresses, one 32-bit word each)
	// ************************************************************
	localparam logic [7:0] FS_ADJUST_ADDR = 8'h00;
	localparam logic [7:0] MODE_STATUS_ADDR = 8'h04;
	localparam int         ADDR_W = 8;

	// ************************************************************
	// Full-scale adjust field
	// ************************************************************
	localparam int         FS_W = 8;
	localparam logic [7:0] FS_ADJUST_RESET = 8'h80;
	localparam logic [7:0] FS_CODE_LOW = 8'h00;
	localparam logic [7:0] FS_CODE_HIGH = 8'hFF;

	// ************************************************************
	// Mode status field positions
	// ************************************************************
	localparam int STAT_EXT_ACTIVE = 0;
	localparam int STAT_REALIGN_DIFF = 1;
	localparam int STAT_FS_HIGH = 2;
	localparam int STAT_CAL_ACTIVE = 3;
	localparam int STAT_ALT_REQUEST = 4;
	localparam int STAT_EXT_BY_PIN = 5;

endpackage

// ===== cms_strap_decode.sv
// Combinational decode of the control mode strap pins
`timescale 1ns/1ps
`default_nettype none

module cms_strap_decode
(
	input  wire logic extended_control_select_n_i,
	input  wire logic extended_control_select_float_i,
	input  wire logic realign_style_select_i,
	input  wire logic mf_pin_level_i,
	input  wire logic mf_pin_mid_i,
	input  wire logic output_clock_realign_i,
	output logic      ext_active_o,
	output logic      ext_by_pin_o,
	output logic      alt_request_o,
	output logic      realign_diff_o,
	output logic      fs_high_o,
	output logic      realign_pos_o,
	output logic      realign_neg_o
);

	// ************************************************************
	// Mode resolution, re-evaluated on every pin change
	// ************************************************************
	always_comb
	begin
		// Style pin pulls high when left open, so high means single-ended
		realign_diff_o = !realign_style_select_i;
		// Mid-level on the shared pin asks for extended control in single-ended mode only
		alt_request_o = !realign_diff_o && mf_pin_mid_i;
		ext_by_pin_o = !extended_control_select_n_i
			&& !extended_control_select_float_i;
		// The dedicated pin decides whenever it is driven
		if (!extended_control_select_float_i)
			ext_active_o = !extended_control_select_n_i;
		else
			ext_active_o = alt_request_o;
		// Differential mode has no pin range: higher range by default
		if (realign_diff_o)
			fs_high_o = 1'b1;
		else
			fs_high_o = mf_pin_level_i;
		realign_pos_o = output_clock_realign_i;
		// Single-ended mode leaves the negative leg idle low
		realign_neg_o = realign_diff_o && mf_pin_level_i;
	end

endmodule

`default_nettype wire

// ===== cms_control_mode_select.sv
// Control mode pin select with Wishbone register access
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module cms_control_mode_select
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Strap and control pins
	input  wire logic        extended_control_select_n_i,
	input  wire logic        extended_control_select_float_i,
	input  wire logic        realign_style_select_i,
	input  wire logic        mf_pin_level_i,
	input  wire logic        mf_pin_mid_i,
	input  wire logic        output_clock_realign_i,
	input  wire logic        calibration_busy_i,
	// Resolved configuration
	output logic             calibration_active_flag_o,
	output logic             extended_control_active_o,
	output logic             realign_differential_o,
	output logic             output_clock_realign_pos_o,
	output logic             output_clock_realign_neg_o,
	output logic [7:0]       full_scale_range_o
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic       ext_active;
	logic       ext_by_pin;
	logic       alt_request;
	logic       realign_diff;
	logic       fs_high_pin;
	logic       ack_ff;
	logic [31:0] dat_ff;
	logic [7:0] fs_adjust_ff;
	logic       cal_active_ff;
	logic       req;
	logic       fs_write;

	function automatic logic is_addr(input logic [7:0] a,
		input logic [7:0] ref_a);
		is_addr = (a == ref_a);
	endfunction

	// ************************************************************
	// Strap decode
	// ************************************************************
	cms_strap_decode u_decode
	(
		.extended_control_select_n_i     (extended_control_select_n_i),
		.extended_control_select_float_i (extended_control_select_float_i),
		.realign_style_select_i          (realign_style_select_i),
		.mf_pin_level_i                  (mf_pin_level_i),
		.mf_pin_mid_i                    (mf_pin_mid_i),
		.output_clock_realign_i          (output_clock_realign_i),
		.ext_active_o                    (ext_active),
		.ext_by_pin_o                    (ext_by_pin),
		.alt_request_o                   (alt_request),
		.realign_diff_o                  (realign_diff),
		.fs_high_o                       (fs_high_pin),
		.realign_pos_o                   (output_clock_realign_pos_o),
		.realign_neg_o                   (output_clock_realign_neg_o)
	);

	// Mode outputs stay combinational so straps act without a reset
	assign extended_control_active_o = ext_active;
	assign realign_differential_o = realign_diff;

	// ************************************************************
	// Full-scale range selection
	// ************************************************************
	always_comb
	begin
		if (ext_active)
			full_scale_range_o = fs_adjust_ff;
		else if (fs_high_pin)
			full_scale_range_o = cms_pkg::FS_CODE_HIGH;
		else
			full_scale_range_o = cms_pkg::FS_CODE_LOW;
	end

	// ************************************************************
	// Calibration running flag
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cal_active_ff <= 1'b0;
		else
			cal_active_ff <= calibration_busy_i;
	end

	assign calibration_active_flag_o = cal_active_ff;

	// ************************************************************
	// Wishbone slave: one wait state, ack drops after one cycle
	// ************************************************************
	assign req = cyc_i && stb_i && !ack_ff;
	assign fs_write = req && we_i && sel_i[0]
		&& is_addr(adr_i, cms_pkg::FS_ADJUST_ADDR);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_ff <= 1'b0;
		else
			ack_ff <= req;
	end

	assign ack_o = ack_ff;

	// Writes are still acknowledged when refused, so software never hangs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fs_adjust_ff <= cms_pkg::FS_ADJUST_RESET;
		else if (fs_write && ext_by_pin)
			fs_adjust_ff <= dat_i[7:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_ff <= 32'h0000_0000;
		else if (req && !we_i)
		begin
			dat_ff <= 32'h0000_0000;
			if (is_addr(adr_i, cms_pkg::FS_ADJUST_ADDR))
				dat_ff[7:0] <= fs_adjust_ff;
			else if (is_addr(adr_i, cms_pkg::MODE_STATUS_ADDR))
			begin
				dat_ff[cms_pkg::STAT_EXT_ACTIVE] <= ext_active;
				dat_ff[cms_pkg::STAT_REALIGN_DIFF] <= realign_diff;
				dat_ff[cms_pkg::STAT_FS_HIGH] <= fs_high_pin;
				dat_ff[cms_pkg::STAT_CAL_ACTIVE] <= cal_active_ff;
				dat_ff[cms_pkg::STAT_ALT_REQUEST] <= alt_request;
				dat_ff[cms_pkg::STAT_EXT_BY_PIN] <= ext_by_pin;
			end
		end
	end

	assign dat_o = dat_ff;

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_cal_follows;
		@(posedge clk_i) disable iff (rst_i)
		calibration_busy_i |=> calibration_active_flag_o;
	endproperty
	a_cal_follows: assert property (p_cal_follows)
		else $error("calibration flag not high after busy");

	property p_cal_clears;
		@(posedge clk_i) disable iff (rst_i)
		$fell(calibration_busy_i) |=> !calibration_active_flag_o;
	endproperty
	a_cal_clears: assert property (p_cal_clears)
		else $error("calibration flag stuck after busy ended");

	property p_ext_off;
		@(posedge clk_i) disable iff (rst_i)
		extended_control_select_n_i && !extended_control_select_float_i
			|-> !extended_control_active_o;
	endproperty
	a_ext_off: assert property (p_ext_off)
		else $error("extended mode active with select high");

	property p_ext_on;
		@(posedge clk_i) disable iff (rst_i)
		!extended_control_select_n_i && !extended_control_select_float_i
			|-> extended_control_active_o;
	endproperty
	a_ext_on: assert property (p_ext_on)
		else $error("extended mode inactive with select low");

	property p_override;
		@(posedge clk_i) disable iff (rst_i)
		extended_control_select_n_i && !extended_control_select_float_i
			&& mf_pin_mid_i && realign_style_select_i
			|-> !extended_control_active_o
			&& full_scale_range_o == (mf_pin_level_i
			? cms_pkg::FS_CODE_HIGH : cms_pkg::FS_CODE_LOW);
	endproperty
	a_override: assert property (p_override)
		else $error("alternate enable overrode dedicated select");

	property p_single_ended;
		@(posedge clk_i) disable iff (rst_i)
		realign_style_select_i |-> !realign_differential_o
			&& !output_clock_realign_neg_o;
	endproperty
	a_single_ended: assert property (p_single_ended)
		else $error("differential realign with style high");

	property p_diff_legs;
		@(posedge clk_i) disable iff (rst_i)
		!realign_style_select_i |-> realign_differential_o
			&& output_clock_realign_pos_o == output_clock_realign_i
			&& output_clock_realign_neg_o == mf_pin_level_i;
	endproperty
	a_diff_legs: assert property (p_diff_legs)
		else $error("differential legs misrouted");

	property p_diff_range;
		@(posedge clk_i) disable iff (rst_i)
		!realign_style_select_i && !extended_control_active_o
			|-> full_scale_range_o == cms_pkg::FS_CODE_HIGH;
	endproperty
	a_diff_range: assert property (p_diff_range)
		else $error("differential mode range not high");

	property p_write_refused;
		@(posedge clk_i) disable iff (rst_i)
		fs_write && extended_control_select_n_i |=> $stable(fs_adjust_ff);
	endproperty
	a_write_refused: assert property (p_write_refused)
		else $error("full-scale adjust written outside extended mode");

	property p_range_source;
		@(posedge clk_i) disable iff (rst_i)
		extended_control_active_o |-> full_scale_range_o == fs_adjust_ff;
	endproperty
	a_range_source: assert property (p_range_source)
		else $error("extended mode range not from register");

	property p_range_low;
		@(posedge clk_i) disable iff (rst_i)
		!extended_control_active_o && realign_style_select_i
			&& !mf_pin_level_i
			|-> full_scale_range_o == cms_pkg::FS_CODE_LOW;
	endproperty
	a_range_low: assert property (p_range_low)
		else $error("low shared pin did not select reduced range");

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack not a single cycle after request");

endmodule

`default_nettype wire

// ===== cms_board_model.sv
// Board strap pins and calibration sequencer seen from the converter
`timescale 1ns/1ps
`default_nettype none

module cms_board_model
(
	input  wire logic       clk_i,
	input  wire logic [6:0] pick_i,
	output logic            sel_n_o,
	output logic            float_o,
	output logic            style_o,
	output logic            level_o,
	output logic            mid_o,
	output logic            realign_o,
	output logic            busy_o
);
	// ************************************************************
	// Strap settling
	// ************************************************************
	// Straps move only just after an edge, so the bench never races them
	always @(posedge clk_i)
	begin
		{busy_o, realign_o, mid_o, level_o, style_o, float_o, sel_n_o} <= pick_i;
	end
endmodule
`default_nettype wire

// ===== cms_control_mode_select_test.sv
// Self-checking bench for the control mode pin select block
`timescale 1ns/1ps
`default_nettype none

module cms_control_mode_select_test;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [7:0]  adr_i, fs_reg, exp_fs, fs_o;
	logic [6:0]  pick;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, rd, d;
	logic        sel_n, flt, style, level, mid, realign, busy;
	logic        cal_o, ext_o, diff_o, pos_o, neg_o;
	bit          e_ext, e_diff, e_alt, wr_ok;
	int          err_count, check_count, cycles;

	// ************************************************************
	// Instances and clock
	// ************************************************************
	cms_board_model cms_board_model_inst (.clk_i(clk_i), .pick_i(pick),
		.sel_n_o(sel_n), .float_o(flt), .style_o(style), .level_o(level),
		.mid_o(mid), .realign_o(realign), .busy_o(busy));

	cms_control_mode_select cms_control_mode_select_inst (.clk_i(clk_i),
		.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .extended_control_select_n_i(sel_n),
		.extended_control_select_float_i(flt),
		.realign_style_select_i(style), .mf_pin_level_i(level),
		.mf_pin_mid_i(mid), .output_clock_realign_i(realign),
		.calibration_busy_i(busy), .calibration_active_flag_o(cal_o),
		.extended_control_active_o(ext_o), .realign_differential_o(diff_o),
		.output_clock_realign_pos_o(pos_o),
		.output_clock_realign_neg_o(neg_o), .full_scale_range_o(fs_o));

	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic give_verdict();
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; waits for ack with its own bound
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= wd;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			err_count++;
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			err_count++;
			give_verdict();
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		{cyc_i, stb_i, we_i, rst_i} = 4'h1;
		{adr_i, sel_i, dat_i, pick} = '0;
		{err_count, check_count, cycles} = '0;
		void'($urandom(96088));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		fs_reg = cms_pkg::FS_ADJUST_RESET;
		wb(1'b0, cms_pkg::FS_ADJUST_ADDR, 32'h0, rd);
		chk(rd, 32'h80);
		for (int i = 0; i < 64; i++)
		begin
			pick <= 7'($urandom);
			repeat (3) @(posedge clk_i);
			e_diff = !style;
			e_alt = mid && !e_diff;
			wr_ok = !sel_n && !flt;
			e_ext = flt ? e_alt : !sel_n;
			chk(32'(ext_o), 32'(e_ext));
			chk(32'(diff_o), 32'(e_diff));
			chk(32'(pos_o), 32'(realign));
			chk(32'(neg_o), 32'(e_diff & level));
			chk(32'(cal_o), 32'(busy));
			d = $urandom;
			sel_i <= 4'($urandom);
			wb(1'b1, cms_pkg::FS_ADJUST_ADDR, d, rd);
			if (wr_ok && sel_i[0])
				fs_reg = d[7:0];
			wb(1'b0, cms_pkg::FS_ADJUST_ADDR, 32'h0, rd);
			chk(rd, 32'(fs_reg));
			exp_fs = e_ext ? fs_reg : ((e_diff || level) ? 8'hFF : 8'h00);
			chk(32'(fs_o), 32'(exp_fs));
			wb(1'b0, cms_pkg::MODE_STATUS_ADDR, 32'h0, rd);
			chk(rd & 32'h3F, 32'({wr_ok, e_alt, busy, e_diff || level,
				e_diff, e_ext}));
			wb(1'b0, 8'h08, 32'h0, rd);
			chk(rd, 32'h0);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
